// ==== rtl/tdt_top.sv ====
/*
 * Dual 8-bit timer with capture, auto-reload and 16-bit cascade,
 * behind an Avalon-MM slave with one wait state.
 * Assumes all pin inputs are asynchronous and each level lasts
 * longer than two system clocks; high-speed clock below 2.5 MHz.
 */
// What this block does
// - Timer 1 modes by capture and run bits
// - Timer 1 clock select field, eight sources
// - Timer 0 overflow clocks timer 1 cascade
// - Reset clears all status flag bits
// - Pin change captures, flag blocks further captures
// - Reading timer 0 flags clears capture flag
// - Timer 1 captures likewise on own pin; in cascade on timer 0 pin
// - Overflow flag resets low, toggles per overflow
// - Clock choices time-base, fast, divided, external
// - External clock sampled by system clock
// - External clocks come from dedicated pins
// - Auto-reload copies hold into counter on overflow
// - Capture loads hold with counter value
// - Hold write leaves counter unchanged
// - Eight-bit up-counter steps on clock fall
// - Counter access while counting not guaranteed
// - Counter write also writes hold nibble
// - Interrupt request on each counter overflow, except timer 0 in cascade
// - Capture mode wraps to zero, no reload
// - Run bit starts and stops; cascade uses timer 0
module tdt_top
    import tdt_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        arst_n_i,
    // Avalon-MM slave
    input  wire logic [9:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    // Clock source pins
    input  wire logic        time_base_clock_i,
    input  wire logic        high_speed_clock_i,
    input  wire logic        t0_external_clock_pin_i,
    input  wire logic        t1_external_clock_pin_i,
    // Capture pins
    input  wire logic        t0_capture_pin_i,
    input  wire logic        t1_capture_pin_i,
    // Overflow outputs
    output logic             t0_overflow_toggle_o,
    output logic             t1_overflow_toggle_o,
    output logic             t0_irq_o,
    output logic             t1_irq_o
);

    typedef struct packed {
        logic       ack;      // Bus answer cycle
        logic [3:0] rdata;    // Read data nibble
        logic [7:0] cnt0;     // Timer 0 counter
        logic [7:0] cnt1;     // Timer 1 counter
        logic [7:0] hold0;    // Timer 0 hold
        logic [7:0] hold1;    // Timer 1 hold
        logic [2:0] mode0;    // Fmeas, capture, run
        logic [1:0] mode1;    // Capture, run
        logic [2:0] csel0;    // Timer 0 clock select
        logic [2:0] csel1;    // Timer 1 clock select
        logic [1:0] capf;     // New-capture flags
        logic [1:0] ovf;      // Overflow toggles
        logic [1:0] cprev;    // Capture pin last level
        logic [1:0] irq;      // Interrupt pulses
        logic       hs_prev;  // Fast clock last level
        logic [4:0] div;      // Fast clock divider
    } tdt_state_t;

    tdt_state_t state_q;      // Registered state
    tdt_state_t state_d;      // Next state

    logic       rst_n;        // Released reset
    logic [5:0] pin_s;        // Synchronised pins
    logic       tbc_s;        // Time-base level
    logic       hs_s;         // Fast clock level
    logic [1:0] ext_s;        // External clock levels
    logic [1:0] cap_s;        // Capture pin levels
    logic [7:0] src0;         // Timer 0 sources
    logic [7:0] src1;         // Timer 1 sources
    logic       tick0;        // Timer 0 clock fall
    logic       tick1_raw;    // Timer 1 clock fall
    logic       tick1;        // Timer 1 step event
    logic       req;          // Bus request present
    logic       rd_done;      // Read completes
    logic       wr_done;      // Write completes
    logic [7:0] idx;          // Register index
    logic       aligned;      // Word aligned address
    logic [3:0] wnib;         // Write nibble
    logic [3:0] rd_val;       // Read mux output
    logic       casc;         // 16-bit cascade mode
    logic       run0;         // Timer 0 counting
    logic       run1;         // Timer 1 counting
    logic       capm0;        // Timer 0 capture mode
    logic       capm1;        // Timer 1 capture mode
    logic       adv0;         // Timer 0 steps
    logic       adv1;         // Timer 1 steps
    logic       cw0;          // Timer 0 counter written
    logic       cw1;          // Timer 1 counter written
    logic       ovf0;         // Timer 0 overflow event
    logic       ovf1;         // Timer 1 overflow event
    logic [1:0] chg;          // Capture pin changed
    logic       capev0;       // Timer 0 capture event
    logic       capev1;       // Timer 1 capture event
    logic       clr0;         // Timer 0 flag read clear
    logic       clr1;         // Timer 1 flag read clear

    // Replace one nibble of a byte
    function automatic logic [7:0] set_nib(
        input logic [7:0] b,
        input logic       hi,
        input logic [3:0] v
    );
        set_nib = hi ? {v, b[3:0]} : {b[7:4], v};
    endfunction

    // Counter step, reload or wrap
    function automatic logic [7:0] cnt_next(
        input logic [7:0] c,
        input logic [7:0] h,
        input logic       adv,
        input logic       ovf,
        input logic       capm
    );
        if (ovf)
            cnt_next = capm ? CNT_WRAP : h;
        else if (adv)
            cnt_next = c + 8'h01;
        else
            cnt_next = c;
    endfunction

    // Completed write to one index
    function automatic logic wr_at(
        input logic       done,
        input logic [7:0] i,
        input logic [7:0] at
    );
        wr_at = done && (i == at);
    endfunction

    // Reset release chain
    tdt_sync #(
        .W (1)
    ) u_rst_sync (
        .clk_i    (clk_sys_i),
        .arst_n_i (arst_n_i),
        .d_i      (1'b1),
        .q_o      (rst_n)
    );

    // All pins pass two flops first
    tdt_sync #(
        .W (6)
    ) u_pin_sync (
        .clk_i    (clk_sys_i),
        .arst_n_i (rst_n),
        .d_i      ({t1_capture_pin_i, t0_capture_pin_i,
                    t1_external_clock_pin_i,
                    t0_external_clock_pin_i,
                    high_speed_clock_i, time_base_clock_i}),
        .q_o      (pin_s)
    );

    assign tbc_s = pin_s[0];
    assign hs_s  = pin_s[1];
    assign ext_s = pin_s[3:2];
    assign cap_s = pin_s[5:4];

    // Timer 0 adds the divide-by-32 tap
    assign src0 = {ext_s[0], state_q.div, hs_s, tbc_s};
    // Cascade code is handled as an event, not a level
    assign src1 = {1'b0, ext_s[1], state_q.div[3:0],
                   hs_s, tbc_s};

    tdt_clk_sel u_cs0 (
        .clk_i   (clk_sys_i),
        .rst_n_i (rst_n),
        .sel_i   (state_q.csel0),
        .src_i   (src0),
        .tick_o  (tick0)
    );

    tdt_clk_sel u_cs1 (
        .clk_i   (clk_sys_i),
        .rst_n_i (rst_n),
        .sel_i   (state_q.csel1),
        .src_i   (src1),
        .tick_o  (tick1_raw)
    );

    // Bus decode; one wait state per access
    assign req     = avs_read_i | avs_write_i;
    assign aligned = (avs_address_i[1:0] == 2'h0);
    assign idx     = aligned ? avs_address_i[9:2] : 8'h00;
    assign wnib    = avs_writedata_i[3:0];
    assign rd_done = avs_read_i & state_q.ack;
    assign wr_done = avs_write_i & state_q.ack
                   & avs_byteenable_i[0];

    // Mode decode
    assign casc  = (state_q.csel1 == CS_CASC);
    assign run0  = state_q.mode0[RUN_BIT]
                 & ~state_q.mode0[FMEAS_BIT];
    // Cascade: timer 1 runs regardless of its own run bit
    assign run1  = casc | state_q.mode1[RUN_BIT];
    assign capm0 = state_q.mode0[CAPE_BIT]
                 & ~state_q.mode0[FMEAS_BIT];
    assign capm1 = state_q.mode1[CAPE_BIT];
    assign tick1 = casc ? ovf0 : tick1_raw;

    // Software write wins over a same-cycle step
    assign cw0 = wr_at(wr_done, idx, IDX_T0_CNT_LO)
               | wr_at(wr_done, idx, IDX_T0_CNT_HI);
    assign cw1 = wr_at(wr_done, idx, IDX_T1_CNT_LO)
               | wr_at(wr_done, idx, IDX_T1_CNT_HI);
    assign adv0 = tick0 & run0;
    assign adv1 = tick1 & run1;
    assign ovf0 = adv0 & (state_q.cnt0 == CNT_MAX) & ~cw0;
    assign ovf1 = adv1 & (state_q.cnt1 == CNT_MAX) & ~cw1;

    // Capture trigger: any level change while running
    assign chg    = cap_s ^ state_q.cprev;
    assign capev0 = capm0 & run0 & chg[0]
                  & ~state_q.capf[0];
    // 16-bit capture is triggered from timer 0 pin
    assign capev1 = capm1 & run1 & (casc ? chg[0] : chg[1])
                  & ~state_q.capf[1];

    // Clear only a flag the read actually reported
    assign clr0 = rd_done & (idx == IDX_T0_FLAGS)
                & state_q.rdata[CAPF_BIT];
    assign clr1 = rd_done & (idx == IDX_T1_FLAGS)
                & state_q.rdata[CAPF_BIT];

    // Read mux; unused bits read as one
    always_comb
    begin
        case (idx)
            IDX_T0_HOLD_LO: rd_val = state_q.hold0[3:0];
            IDX_T0_HOLD_HI: rd_val = state_q.hold0[7:4];
            IDX_T1_HOLD_LO: rd_val = state_q.hold1[3:0];
            IDX_T1_HOLD_HI: rd_val = state_q.hold1[7:4];
            IDX_T0_CNT_LO:  rd_val = state_q.cnt0[3:0];
            IDX_T0_CNT_HI:  rd_val = state_q.cnt0[7:4];
            IDX_T1_CNT_LO:  rd_val = state_q.cnt1[3:0];
            IDX_T1_CNT_HI:  rd_val = state_q.cnt1[7:4];
            IDX_T0_MODE:    rd_val = T0_MODE_RST
                                   | {1'b0, state_q.mode0};
            IDX_T0_CLK:     rd_val = T0_CLK_RST
                                   | {1'b0, state_q.csel0};
            IDX_T1_MODE:    rd_val = T1_MODE_RST
                                   | {2'b00, state_q.mode1};
            IDX_T1_CLK:     rd_val = T1_CLK_RST
                                   | {1'b0, state_q.csel1};
            IDX_T0_FLAGS:   rd_val = FLAGS_RST
                                   | {2'b00, state_q.capf[0],
                                      state_q.ovf[0]};
            IDX_T1_FLAGS:   rd_val = FLAGS_RST
                                   | {2'b00, state_q.capf[1],
                                      state_q.ovf[1]};
            // Unmapped reads return zero
            default:        rd_val = 4'h0;
        endcase
    end

    // Next-state logic for the whole block
    always_comb
    begin
        state_d = state_q;
        // Answer one cycle after the request appears
        state_d.ack = req & ~state_q.ack;
        if (req & ~state_q.ack)
        begin
            state_d.rdata = rd_val;
        end
        // Fast clock divider steps on each fall
        state_d.hs_prev = hs_s;
        if (state_q.hs_prev & ~hs_s)
        begin
            state_d.div = state_q.div + 5'h01;
        end
        state_d.cprev = cap_s;
        // Counters
        state_d.cnt0 = cnt_next(state_q.cnt0, state_q.hold0,
                                adv0, ovf0, capm0);
        state_d.cnt1 = cnt_next(state_q.cnt1, state_q.hold1,
                                adv1, ovf1, capm1);
        // Capture copies the counter into hold
        if (capev0)
        begin
            state_d.hold0 = state_q.cnt0;
        end
        if (capev1)
        begin
            state_d.hold1 = state_q.cnt1;
        end
        // Set wins over a same-cycle read clear
        state_d.capf[0] = capev0 | (state_q.capf[0] & ~clr0);
        state_d.capf[1] = capev1 | (state_q.capf[1] & ~clr1);
        // Overflow toggles and interrupt pulses
        state_d.ovf[0] = state_q.ovf[0] ^ ovf0;
        state_d.ovf[1] = state_q.ovf[1] ^ ovf1;
        // In cascade only timer 1 raises the request
        state_d.irq[0] = ovf0 & ~casc;
        state_d.irq[1] = ovf1;
        // Software writes to hold: counter untouched
        if (wr_at(wr_done, idx, IDX_T0_HOLD_LO))
            state_d.hold0 = set_nib(state_q.hold0, 1'b0, wnib);
        if (wr_at(wr_done, idx, IDX_T0_HOLD_HI))
            state_d.hold0 = set_nib(state_q.hold0, 1'b1, wnib);
        if (wr_at(wr_done, idx, IDX_T1_HOLD_LO))
            state_d.hold1 = set_nib(state_q.hold1, 1'b0, wnib);
        if (wr_at(wr_done, idx, IDX_T1_HOLD_HI))
            state_d.hold1 = set_nib(state_q.hold1, 1'b1, wnib);
        // Counter writes also land in hold
        if (wr_at(wr_done, idx, IDX_T0_CNT_LO))
        begin
            state_d.cnt0  = set_nib(state_q.cnt0, 1'b0, wnib);
            state_d.hold0 = set_nib(state_q.hold0, 1'b0, wnib);
        end
        if (wr_at(wr_done, idx, IDX_T0_CNT_HI))
        begin
            state_d.cnt0  = set_nib(state_q.cnt0, 1'b1, wnib);
            state_d.hold0 = set_nib(state_q.hold0, 1'b1, wnib);
        end
        if (wr_at(wr_done, idx, IDX_T1_CNT_LO))
        begin
            state_d.cnt1  = set_nib(state_q.cnt1, 1'b0, wnib);
            state_d.hold1 = set_nib(state_q.hold1, 1'b0, wnib);
        end
        if (wr_at(wr_done, idx, IDX_T1_CNT_HI))
        begin
            state_d.cnt1  = set_nib(state_q.cnt1, 1'b1, wnib);
            state_d.hold1 = set_nib(state_q.hold1, 1'b1, wnib);
        end
        // Control registers
        if (wr_at(wr_done, idx, IDX_T0_MODE))
            state_d.mode0 = wnib[2:0];
        if (wr_at(wr_done, idx, IDX_T0_CLK))
            state_d.csel0 = wnib[2:0];
        if (wr_at(wr_done, idx, IDX_T1_MODE))
            state_d.mode1 = wnib[1:0];
        if (wr_at(wr_done, idx, IDX_T1_CLK))
            state_d.csel1 = wnib[2:0];
    end

    // State register; all flags clear on reset
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q       <= '0;
            state_q.hold0 <= {NIB_RST, NIB_RST};
            state_q.hold1 <= {NIB_RST, NIB_RST};
            state_q.cnt0  <= {NIB_RST, NIB_RST};
            state_q.cnt1  <= {NIB_RST, NIB_RST};
            state_q.mode0 <= T0_MODE_RST[2:0];
            state_q.mode1 <= T1_MODE_RST[1:0];
            state_q.csel0 <= T0_CLK_RST[2:0];
            state_q.csel1 <= CS_TBC;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // Outputs
    assign avs_waitrequest_o    = req & ~state_q.ack;
    assign avs_readdata_o       = {28'h0, state_q.rdata};
    assign t0_overflow_toggle_o = state_q.ovf[0];
    assign t1_overflow_toggle_o = state_q.ovf[1];
    assign t0_irq_o             = state_q.irq[0];
    assign t1_irq_o             = state_q.irq[1];

    // Checks
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n);

    property p_bus_answer;
        (req && !state_q.ack) |-> avs_waitrequest_o
            ##1 !avs_waitrequest_o;
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("bus answer not after one wait");

    property p_cap_clear;
        (clr0 && !capev0) |=> !state_q.capf[0];
    endproperty
    a_cap_clear: assert property (p_cap_clear)
        else $error("flag read did not clear capture");

    property p_cap_block;
        (state_q.capf[0] && !wr_done) |=> $stable(state_q.hold0);
    endproperty
    a_cap_block: assert property (p_cap_block)
        else $error("hold changed while capture flag set");

    property p_ovf_toggle;
        ovf1 |=> (state_q.ovf[1] != $past(state_q.ovf[1]))
            && t1_irq_o;
    endproperty
    a_ovf_toggle: assert property (p_ovf_toggle)
        else $error("overflow did not toggle or request");

    property p_reload;
        (ovf0 && !capm0) |=> (state_q.cnt0 == $past(state_q.hold0));
    endproperty
    a_reload: assert property (p_reload)
        else $error("auto reload value wrong");

    property p_wrap;
        (ovf0 && capm0) |=> (state_q.cnt0 == CNT_WRAP);
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("capture mode did not wrap to zero");

    property p_cnt_to_hold;
        wr_at(wr_done, idx, IDX_T1_CNT_HI) |=>
            (state_q.hold1[7:4] == $past(wnib))
            && (state_q.cnt1[7:4] == $past(wnib));
    endproperty
    a_cnt_to_hold: assert property (p_cnt_to_hold)
        else $error("counter write missed hold");

    property p_hold_only;
        (wr_at(wr_done, idx, IDX_T0_HOLD_LO) && !adv0) |=>
            $stable(state_q.cnt0);
    endproperty
    a_hold_only: assert property (p_hold_only)
        else $error("hold write changed counter");

    property p_stopped;
        (!run0 && !cw0) [*2] |=> $stable(state_q.cnt0);
    endproperty
    a_stopped: assert property (p_stopped)
        else $error("stopped counter moved");

    // At FF timer 1 overflows and reloads or wraps instead of stepping, so FF is left out
    property p_cascade;
        (casc && ovf0 && !cw1 && (state_q.cnt1 != CNT_MAX)) |=>
            (state_q.cnt1 == $past(state_q.cnt1) + 8'h01) && !t0_irq_o;
    endproperty
    a_cascade: assert property (p_cascade)
        else $error("cascade step or request wrong");

    c_capture: cover property (capev0 ##[1:50] clr0);
    c_casc_ovf: cover property (casc && ovf1);
    c_t1_capture: cover property (capev1);

endmodule

// ==== rtl/tdt_pkg.sv ====
/*
 * Constants for the dual 8-bit timer with capture.
 * Assumes a byte-addressed Avalon-MM bus; each register index
 * sits at byte address four times the index.
 */
package tdt_pkg;

    // Register indices (byte address = 4 * index)
    localparam logic [7:0] IDX_T0_HOLD_LO  = 8'h68;
    localparam logic [7:0] IDX_T0_HOLD_HI  = 8'h69;
    localparam logic [7:0] IDX_T1_HOLD_LO  = 8'h6A;
    localparam logic [7:0] IDX_T1_HOLD_HI  = 8'h6B;
    localparam logic [7:0] IDX_T0_CNT_LO   = 8'h6C;
    localparam logic [7:0] IDX_T0_CNT_HI   = 8'h6D;
    localparam logic [7:0] IDX_T1_CNT_LO   = 8'h6E;
    localparam logic [7:0] IDX_T1_CNT_HI   = 8'h6F;
    localparam logic [7:0] IDX_T0_MODE     = 8'h70;
    localparam logic [7:0] IDX_T0_CLK      = 8'h71;
    localparam logic [7:0] IDX_T1_MODE     = 8'h72;
    localparam logic [7:0] IDX_T1_CLK      = 8'h73;
    localparam logic [7:0] IDX_T0_FLAGS    = 8'h74;
    localparam logic [7:0] IDX_T1_FLAGS    = 8'h75;

    // Reset values; unimplemented bits read as one
    localparam logic [3:0] NIB_RST         = 4'h0;
    localparam logic [3:0] T0_MODE_RST     = 4'h8;
    localparam logic [3:0] T0_CLK_RST      = 4'h8;
    localparam logic [3:0] T1_MODE_RST     = 4'hC;
    localparam logic [3:0] T1_CLK_RST      = 4'h8;
    localparam logic [3:0] FLAGS_RST       = 4'hC;

    // Mode control fields
    localparam int RUN_BIT   = 0;
    localparam int CAPE_BIT  = 1;
    localparam int FMEAS_BIT = 2;

    // Flags register fields
    localparam int OVF_BIT   = 0;
    localparam int CAPF_BIT  = 1;

    // Clock select codes
    localparam logic [2:0] CS_TBC    = 3'h0;
    localparam logic [2:0] CS_EXT1   = 3'h6;
    localparam logic [2:0] CS_CASC   = 3'h7;

    // Counter limits
    localparam logic [7:0] CNT_MAX   = 8'hFF;
    localparam logic [7:0] CNT_WRAP  = 8'h00;

endpackage

// ==== rtl/tdt_sync.sv ====
/*
 * Two-flop synchroniser, also used as the reset release chain.
 * Assumes d_i is asynchronous to clk_i; only q_o may be read.
 */
module tdt_sync
    import tdt_pkg::*;
#(
    parameter int W = 1
)(
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         arst_n_i,
    // Data
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    typedef struct packed {
        logic [W-1:0] meta;   // First stage, read by stab only
        logic [W-1:0] stab;   // Second stage
    } tdt_sync_t;

    tdt_sync_t state_q;       // Registered state
    tdt_sync_t state_d;       // Next state

    // Shift one stage per edge
    always_comb
    begin
        state_d      = state_q;
        state_d.meta = d_i;
        state_d.stab = state_q.meta;
    end

    // Constant on reset only
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            state_q <= '0;
        else
            state_q <= state_d;
    end

    assign q_o = state_q.stab;

endmodule

// ==== rtl/tdt_clk_sel.sv ====
/*
 * Timer clock source selector with falling edge detector.
 * Assumes all src_i bits are already synchronous to clk_i.
 */
module tdt_clk_sel
    import tdt_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // Source choice
    input  wire logic [2:0] sel_i,
    input  wire logic [7:0] src_i,
    // One-cycle tick per falling edge
    output logic            tick_o
);

    typedef struct packed {
        logic prev;           // Selected level last cycle
    } tdt_cs_t;

    tdt_cs_t state_q;         // Registered state
    tdt_cs_t state_d;         // Next state
    logic    cur;             // Selected level now

    // Switching source may yield one spurious tick
    always_comb
    begin
        cur           = src_i[sel_i];
        state_d       = state_q;
        state_d.prev  = cur;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            state_q <= '0;
        else
            state_q <= state_d;
    end

    // Falling edge: high before, low now
    assign tick_o = state_q.prev & ~cur;

endmodule

// ==== verification/tb_top.sv ====
/* Self-checking bench for the dual timer: registers, counting, capture.
   Assumes tdt_top answers each Avalon request after one wait state. */
module tb_top
    import tdt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // Design pins
    logic        clk_sys_i = 0, arst_n_i = 0, rd = 0, wr = 0;
    logic [9:0]  addr = '0;
    logic [31:0] wd = '0, rdat;
    logic        wreq, ov0, ov1, irq0, irq1, cp0 = 0, cp1 = 0;
    logic [2:0]  pn = '0;     // Clock pins: ext0, ext1, time base
    // Bench state
    int          fail_count = 0, checked = 0, cyc = 0, seed = 78248, r;
    int          n0 = 0, n1 = 0;  // Interrupt pulses seen
    logic [3:0]  q, v;
    logic [3:0]  rst_tab [6] = '{4'h8, 4'h8, 4'hC, 4'h8, 4'hC, 4'hC};
    // Fast clock stays low: oscillator never started, so no wait owed
    tdt_top tdt_top_inst (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
        .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wd), .avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wreq), .time_base_clock_i(pn[2]),
        .high_speed_clock_i(1'b0),
        .t0_external_clock_pin_i(pn[0]),
        .t1_external_clock_pin_i(pn[1]), .t0_capture_pin_i(cp0),
        .t1_capture_pin_i(cp1), .t0_overflow_toggle_o(ov0),
        .t1_overflow_toggle_o(ov1), .t0_irq_o(irq0), .t1_irq_o(irq1));
    // Free-running system clock
    initial
    begin
        forever #50 clk_sys_i = ~clk_sys_i;
    end
    // Hang guard, well above the few hundred cycles needed
    always @(posedge clk_sys_i)
    begin
        cyc <= cyc + 1;
        // One-cycle interrupt pulses, counted once each
        if (irq0 === 1'b1)
            n0 <= n0 + 1;
        if (irq1 === 1'b1)
            n1 <= n1 + 1;
        if (cyc > 20000)
        begin
            fail_count++;
            conclude();
        end
    end
    // One bus cycle; request held until waitrequest is seen low
    task automatic acc(input logic w, input logic [7:0] i, input logic [3:0] d);
        @(posedge clk_sys_i);
        addr <= {i, 2'b00};
        rd <= !w;
        wr <= w;
        wd <= {28'h0, d};
        do @(posedge clk_sys_i); while (wreq !== 1'b0);
        q = rdat[3:0];
        rd <= 0;
        wr <= 0;
    endtask
    task automatic chk(input logic [3:0] s, input logic [3:0] e);
        checked++;
        if (s !== e)
        begin
            fail_count++;
            $display("ERROR %0t: saw %h, expected %h", $time, s, e);
        end
    endtask
    // Expected flags read: unused bits one, then capture, overflow
    function automatic logic [3:0] flg(input logic c, input logic o);
        return FLAGS_RST | {2'b00, c, o};
    endfunction
    // One falling edge on clock pin s; each level lasts four clocks
    task automatic tick(input int s);
        pn[s] <= 1;
        repeat (4) @(posedge clk_sys_i);
        pn[s] <= 0;
        repeat (4) @(posedge clk_sys_i);
    endtask
    task automatic conclude();
        $display("checked %0d, fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge clk_sys_i);
        arst_n_i <= 1;
        repeat (3) @(posedge clk_sys_i);
        // Control and flag reset values, then an unmapped index
        for (int k = 0; k < 6; k++)
        begin
            acc(0, IDX_T0_MODE + 8'(k), 4'h0);
            chk(q, rst_tab[k]);
        end
        acc(0, 8'h76, 4'h0);
        chk(q, 4'h0);
        $display("reset test done");
        // Counter write mirrors into hold; hold write spares counter
        v = 4'($random(seed));
        acc(1, IDX_T0_CLK, 4'h7);
        acc(1, IDX_T0_CNT_LO, 4'hE);
        acc(1, IDX_T0_CNT_HI, 4'hF);
        acc(0, IDX_T0_HOLD_LO, 4'h0);
        chk(q, 4'hE);
        acc(1, IDX_T0_HOLD_LO, v);
        acc(1, IDX_T0_HOLD_HI, v);
        acc(0, IDX_T0_CNT_LO, 4'h0);
        chk(q, 4'hE);
        // Run on the external pin: FE, FF, then reload from hold
        acc(1, IDX_T0_MODE, 4'h1);
        tick(0);
        acc(0, IDX_T0_CNT_LO, 4'h0);
        chk(q, 4'hF);
        chk(ov0, 1'b0);
        tick(0);
        acc(0, IDX_T0_CNT_HI, 4'h0);
        chk(q, v);
        chk(ov0, 1'b1);
        $display("reload test done");
        // Timer 1 capture on its own pin; second change is blocked
        r = 1 + ($random(seed) & 3);
        acc(1, IDX_T1_CLK, 4'h6);
        acc(1, IDX_T1_CNT_LO, 4'h0);
        acc(1, IDX_T1_CNT_HI, 4'h0);
        acc(1, IDX_T1_MODE, 4'h3);
        repeat (r) tick(1);
        cp1 <= 1;
        repeat (6) @(posedge clk_sys_i);
        tick(1);
        cp1 <= 0;
        repeat (6) @(posedge clk_sys_i);
        acc(0, IDX_T1_HOLD_LO, 4'h0);
        chk(q, 4'(r));
        acc(0, IDX_T1_FLAGS, 4'h0);
        chk(q, flg(1'b1, 1'b0));
        acc(0, IDX_T1_FLAGS, 4'h0);
        chk(q, flg(1'b0, 1'b0));
        $display("capture test done");
        // Cascade: timer 0 at FF steps timer 1 from FE; t1 run bit off
        acc(1, IDX_T0_CNT_LO, 4'hF);
        acc(1, IDX_T0_CNT_HI, 4'hF);
        acc(1, IDX_T1_MODE, 4'h0);
        acc(1, IDX_T1_CLK, 4'h7);
        acc(1, IDX_T1_CNT_LO, 4'hE);
        acc(1, IDX_T1_CNT_HI, 4'hF);
        tick(0);
        acc(0, IDX_T1_CNT_LO, 4'h0);
        chk(q, 4'hF);
        chk(ov0, 1'b0);
        tick(0);
        acc(0, IDX_T1_CNT_LO, 4'h0);
        chk(q, 4'hE);
        chk(ov1, 1'b1);
        chk(4'(n0), 4'h1);
        // Timer 0 capture mode: wrap to 00, then a pin change captures it
        acc(1, IDX_T0_MODE, 4'h3);
        tick(0);
        cp0 <= 1;
        repeat (6) @(posedge clk_sys_i);
        acc(0, IDX_T0_HOLD_LO, 4'h0);
        chk(q, 4'h0);
        acc(0, IDX_T0_FLAGS, 4'h0);
        chk(q, flg(1'b1, 1'b0));
        acc(0, IDX_T0_FLAGS, 4'h0);
        chk(q, flg(1'b0, 1'b0));
        // Time-base clock steps timer 1 from FF: reload to FE
        acc(1, IDX_T1_CLK, 4'h0);
        acc(1, IDX_T1_MODE, 4'h1);
        tick(2);
        acc(0, IDX_T1_CNT_LO, 4'h0);
        chk(q, 4'hE);
        chk(ov1, 1'b0);
        chk(4'(n1), 4'h2);
        chk(4'(n0), 4'h1);
        $display("cascade test done");
        conclude();
    end
endmodule
